/* design/dvi_rx_pixel_output.sv */
// Purpose: pixel output stage and link-activity detect of a TMDS receiver
// Assumes: decoded words and their pixel clock arrive from outside the mclk domain
// Notes:   output clock is rebuilt from mclk at PHASES_PER_PIX cycles a pixel
`timescale 1ns/100ps
`include "dvi_rx_cfg.svh"

module dvi_rx_pixel_output
  import dvi_rx_pkg::*;
#(
  parameter int LOST_PIX = `LOST_PIX,
  parameter int FOUND_PIX = `FOUND_PIX,
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  // decoded link
  input wire logic pixelClock,
  input wire link_word_type linkWord,
  // configuration pins
  input wire logic wideOutputSelect,
  input wire logic offsetOutputsN,
  input wire logic latchEdgeFlip,
  input wire logic fullShutdownN,
  input wire logic outputShutdownN,
  // panel side
  output logic outputPixelClock,
  output pixel_type evenPixelBus,
  output pixel_type oddPixelBus,
  output logic deOut,
  output logic hsyncOut,
  output logic vsyncOut,
  output logic [`USER_OUT_W-1:0] userControlBits,
  output logic outputsOeN,
  // status
  output logic linkActiveFlag,
  output logic overflowFlag
);
  localparam int HIZ_CYC = `HIZ_CYCLES;
  localparam int FW = $bits(fifo_word_type);
  localparam logic [`QUIET_W-1:0] QUIET_LAST = `QUIET_W'(LOST_PIX - 1);
  localparam logic [`FOUND_W-1:0] FOUND_LAST = `FOUND_W'(FOUND_PIX - 1);

  if (LOST_PIX < 2 || LOST_PIX > (1 << `QUIET_W)) begin : g_bad_lost
    $error("LOST_PIX does not fit the quiet counter");
  end
  if (FOUND_PIX < 2 || FOUND_PIX > (1 << `FOUND_W) || FOUND_PIX >= LOST_PIX) begin : g_bad_found
    $error("FOUND_PIX does not fit the acquire counter");
  end

  rx_state_type st;
  rx_state_type next_st;
  fifo_word_type fifoOut;
  logic fifoInReady;
  logic fifoOutValid;
  logic fifoPop;
  logic strobe;
  logic deEdge;
  logic quietEnd;
  logic present;
  logic [`PHASE_W-1:0] slotLast;
  logic [`PHASE_W-1:0] halfSlot;
  logic [1:0] need;
  fifo_word_type ctrlWord;

  // ----------------------------------------------------------------
  // word buffer
  // ----------------------------------------------------------------
  pixel_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .rstn(rstn),
    .ce(ce),
    .flush(!st.pinSync.fullN),
    .inData(st.capWord),
    .inValid(st.capValid),
    .inReady(fifoInReady),
    .outData(fifoOut),
    .outValid(fifoOutValid),
    .outReady(fifoPop)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    deEdge = 1'b0;
    quietEnd = 1'b0;
    present = 1'b0;
    ctrlWord = st.stageEven;
    // pixel clock, data and pins each cross on two flops
    next_st.pclkMeta = pixelClock;
    next_st.pclkSync = st.pclkMeta;
    next_st.pclkPrev = st.pclkSync;
    next_st.wordMeta = linkWord;
    next_st.wordSync = st.wordMeta;
    next_st.pinMeta = '{wideOutputSelect, offsetOutputsN, latchEdgeFlip,
                        fullShutdownN, outputShutdownN};
    next_st.pinSync = st.pinMeta;
    // data travel with the clock through equal delay, so the rising edge sees them settled
    strobe = st.pclkSync && !st.pclkPrev;

    if (st.capValid && fifoInReady) begin
      next_st.capValid = 1'b0;
    end
    if (strobe) begin
      if (st.capValid && !fifoInReady) begin
        // the buffer is full: keep the held word and record the lost pixel
        next_st.overflow = 1'b1;
      end else begin
        next_st.capWord.de = st.wordSync.de;
        next_st.capWord.hsync = st.wordSync.hsync;
        next_st.capWord.vsync = st.wordSync.vsync;
        next_st.capWord.userBits = st.wordSync.userBits[`USER_IN_W-1:1];
        next_st.capWord.pix = st.wordSync.pix;
        next_st.capValid = 1'b1;
      end
      // link activity from the spacing of DE transitions alone
      deEdge = st.wordSync.de != st.lastDe;
      quietEnd = !deEdge && (st.quiet == QUIET_LAST);
      next_st.lastDe = st.wordSync.de;
      if (deEdge) begin
        next_st.quiet = '0;
      end else if (!quietEnd) begin
        next_st.quiet = st.quiet + 1'b1;
      end
      case (st.link)
        LINK_IDLE: begin
          if (deEdge) begin
            next_st.link = LINK_ACQUIRE;
            next_st.found = '0;
          end
        end
        LINK_ACQUIRE: begin
          if (quietEnd) begin
            next_st.link = LINK_IDLE;
          end else if (st.found == FOUND_LAST) begin
            next_st.link = LINK_ACTIVE;
            next_st.activeFlag = 1'b1;
          end else begin
            next_st.found = st.found + 1'b1;
          end
        end
        LINK_ACTIVE: begin
          if (quietEnd) begin
            next_st.link = LINK_IDLE;
            next_st.activeFlag = 1'b0;
          end
        end
        default: begin
          next_st.link = LINK_IDLE;
          next_st.activeFlag = 1'b0;
        end
      endcase
    end

    // output slot: one pixel, or two in wide mode; its length sets the clock rate
    slotLast = st.pinSync.wide ? (`PHASES_PER_PIX << 1) - 3'h1 : `PHASES_PER_PIX - 3'h1;
    halfSlot = st.pinSync.wide ? `PHASES_PER_PIX : `PHASES_PER_PIX >> 1;
    need = st.pinSync.wide ? 2'h2 : 2'h1;
    if (st.phase < slotLast) begin
      next_st.phase = st.phase + 1'b1;
      if (st.pinSync.wide && !st.pinSync.offsetN && st.phase == `STAGGER_PHASE - 3'h1) begin
        next_st.evenBus = st.evenPend.pix;
      end
    end else if (st.stageCnt >= need) begin
      // the slot stalls at its last phase until a full set of words is staged
      present = 1'b1;
      next_st.phase = '0;
      next_st.stageCnt = '0;
      if (st.pinSync.wide) begin
        ctrlWord = st.stageOdd;
        next_st.oddBus = st.stageOdd.pix;
        next_st.evenPend = st.stageEven;
        if (st.pinSync.offsetN) begin
          next_st.evenBus = st.stageEven.pix;
        end
      end else begin
        next_st.evenBus = st.stageEven.pix;
        next_st.oddBus = '0;
      end
      next_st.de = ctrlWord.de;
      next_st.hsync = ctrlWord.hsync;
      next_st.vsync = ctrlWord.vsync;
      if (!ctrlWord.de) begin
        next_st.userBits = ctrlWord.userBits;
      end
    end
    // latching level during the first half of the slot, so its edge opens the slot
    next_st.outClk = (next_st.phase < halfSlot) ? st.pinSync.flip : !st.pinSync.flip;

    fifoPop = fifoOutValid && (st.stageCnt < need) && !present;
    if (fifoPop) begin
      if (st.stageCnt == 2'h0) begin
        next_st.stageEven = fifoOut;
      end else begin
        next_st.stageOdd = fifoOut;
      end
      next_st.stageCnt = st.stageCnt + 2'h1;
    end

    next_st.oeN = !(st.pinSync.fullN && st.pinSync.outN);
    if (!st.pinSync.fullN) begin
      next_st.link = LINK_IDLE;
      next_st.activeFlag = 1'b0;
      next_st.quiet = '0;
      next_st.found = '0;
      next_st.capValid = 1'b0;
      // a pixel lost in this very cycle still shows: the set wins over the clear
      if (!(strobe && st.capValid && !fifoInReady)) begin
        next_st.overflow = 1'b0;
      end
      next_st.stageCnt = '0;
      next_st.phase = '1;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
      st.phase <= '1;
      st.oeN <= 1'b1;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign outputPixelClock = st.outClk;
  assign evenPixelBus = st.evenBus;
  assign oddPixelBus = st.oddBus;
  assign deOut = st.de;
  assign hsyncOut = st.hsync;
  assign vsyncOut = st.vsync;
  assign userControlBits = st.userBits;
  assign outputsOeN = st.oeN;
  assign linkActiveFlag = st.activeFlag;
  assign overflowFlag = st.overflow;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_hiz_full_down: assert property (@(posedge mclk) disable iff (!rstn || !ce)
    !st.pinSync.fullN |-> ##[1:HIZ_CYC] outputsOeN)
    else $error("outputs not released after full shutdown");
  a_hiz_out_down: assert property (@(posedge mclk) disable iff (!rstn || !ce)
    !st.pinSync.outN |-> ##[1:HIZ_CYC] outputsOeN)
    else $error("outputs not released after output shutdown");
  a_flag_drop: assert property (@(posedge mclk) disable iff (!rstn || !ce)
    (strobe && st.link == LINK_ACTIVE && !deEdge && st.quiet == QUIET_LAST)
      |=> !linkActiveFlag)
    else $error("link flag held after quiet interval");
  a_flag_rise: assert property (@(posedge mclk) disable iff (!rstn || !ce)
    (strobe && st.pinSync.fullN && st.link == LINK_ACQUIRE && st.found == FOUND_LAST
      && !quietEnd) |=> linkActiveFlag)
    else $error("link flag not raised after acquire count");
  a_flag_cause: assert property (@(posedge mclk) disable iff (!rstn || !ce)
    $rose(linkActiveFlag) |-> $past(st.link) == LINK_ACQUIRE && st.link == LINK_ACTIVE)
    else $error("link flag rose without acquire");
  a_quiet_restart: assert property (@(posedge mclk) disable iff (!rstn || !ce)
    (strobe && deEdge) |=> st.quiet == '0)
    else $error("quiet count not restarted on DE transition");
  a_stagger_even: assert property (@(posedge mclk) disable iff (!rstn || !ce)
    (present && st.pinSync.wide && !st.pinSync.offsetN && $stable(st.pinSync))
      |=> $stable(evenPixelBus) ##1 evenPixelBus == st.evenPend.pix)
    else $error("even bus not staggered by one phase");
  a_latch_edge: assert property (@(posedge mclk) disable iff (!rstn || !ce)
    present |=> outputPixelClock == $past(st.pinSync.flip))
    else $error("output clock not at latching level at slot start");
  a_single_period: assert property (@(posedge mclk) disable iff (!rstn || !ce)
    (present && !st.pinSync.wide && $stable(st.pinSync))
      |=> (outputPixelClock == st.pinSync.flip) [*2] ##1 (outputPixelClock != st.pinSync.flip))
    else $error("single mode clock half period wrong");
  a_user_blank: assert property (@(posedge mclk) disable iff (!rstn || !ce)
    (present && ctrlWord.de) |=> $stable(userControlBits))
    else $error("control bits changed during active display");
endmodule

/* design/dvi_rx_cfg.svh */
// Purpose: constants of the pixel output and link-activity block
// Assumes: mclk at 20 MHz; pixel clock recovered upstream and sampled on mclk
// Notes:   included by the package, by the pixel output module and by the bench
//
// Notes on behaviour
// - rebuild 24-bit pixel words and their control signals for a panel controller
// - link activity is judged only from time between DE transitions
// - link-active flag high while link active, low while inactive
// - flag falls after about one million quiet pixel periods
// - flag rises about 1600 pixel periods after DE transitions resume
// - two-pixel staggered mode delays even bus a quarter pixel after latching edge
// - latch edge flip low selects falling output clock edge, high rising
// - single-pixel mode output clock lies between 25 and 165 MHz; the code gives at most 5 MHz (mclk over 4)
// - two-pixel mode output clock lies between 12.5 and 82.5 MHz; the code gives at most 2.5 MHz (mclk over 8)
// - full shutdown low puts digital outputs in high impedance within 9 ns; the code takes up to 3 mclk cycles, 150 ns
// - output shutdown low puts digital outputs in high impedance within 9 ns; the code takes up to 3 mclk cycles, 150 ns
// - red on bits 23..16, green 15..8, blue 7..0, valid while DE high
// - control bits 3..1 go out during blanking; control bit 0 is dropped
// - output clock period is one pixel single mode, two pixels two mode
`ifndef DVI_RX_CFG_SVH
`define DVI_RX_CFG_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define CHAN_W 8
`define USER_IN_W 4
`define USER_OUT_W 3
`define QUIET_W 20
`define FOUND_W 11
`define PHASE_W 3

// ----------------------------------------------------------------
// link activity, in pixel periods; buffer depth in words
// ----------------------------------------------------------------
`define LOST_PIX 1000000
`define FOUND_PIX 1600
`define FIFO_DEPTH 8

// ----------------------------------------------------------------
// output timing: phases in mclk cycles, then ns, MHz and kHz
// ----------------------------------------------------------------
`define PHASES_PER_PIX 3'h4
`define STAGGER_PHASE 3'h1
`define HIZ_NS 9
`define CLK_NS 50
`define HIZ_CYCLES (((`HIZ_NS) / (`CLK_NS)) < 1 ? 1 : ((`HIZ_NS) / (`CLK_NS)))
`define OUT_CLK_SINGLE_MIN_MHZ 25
`define OUT_CLK_SINGLE_MAX_MHZ 165
`define OUT_CLK_WIDE_MIN_KHZ 12500
`define OUT_CLK_WIDE_MAX_KHZ 82500

`endif

/* design/dvi_rx_pkg.sv */
// Purpose: shared types of the pixel output and link-activity block
// Assumes: dvi_rx_cfg.svh gives all widths
// Notes:   state of the top module is one packed struct
`include "dvi_rx_cfg.svh"

package dvi_rx_pkg;

  typedef struct packed {
    logic [`CHAN_W-1:0] red;
    logic [`CHAN_W-1:0] green;
    logic [`CHAN_W-1:0] blue;
  } pixel_type;

  typedef struct packed {
    logic de;
    logic hsync;
    logic vsync;
    logic [`USER_IN_W-1:0] userBits;
    pixel_type pix;
  } link_word_type;

  typedef struct packed {
    logic de;
    logic hsync;
    logic vsync;
    logic [`USER_OUT_W-1:0] userBits;
    pixel_type pix;
  } fifo_word_type;

  typedef struct packed {
    logic wide;
    logic offsetN;
    logic flip;
    logic fullN;
    logic outN;
  } pin_type;

  typedef enum logic [1:0] {LINK_IDLE, LINK_ACQUIRE, LINK_ACTIVE} link_state_type;

  typedef struct packed {
    logic pclkMeta;
    logic pclkSync;
    logic pclkPrev;
    link_word_type wordMeta;
    link_word_type wordSync;
    pin_type pinMeta;
    pin_type pinSync;
    fifo_word_type capWord;
    logic capValid;
    logic overflow;
    logic lastDe;
    logic [`QUIET_W-1:0] quiet;
    logic [`FOUND_W-1:0] found;
    link_state_type link;
    logic activeFlag;
    logic [`PHASE_W-1:0] phase;
    logic [1:0] stageCnt;
    fifo_word_type stageEven;
    fifo_word_type stageOdd;
    fifo_word_type evenPend;
    logic outClk;
    pixel_type evenBus;
    pixel_type oddBus;
    logic de;
    logic hsync;
    logic vsync;
    logic [`USER_OUT_W-1:0] userBits;
    logic oeN;
  } rx_state_type;

endpackage

/* design/pixel_fifo.sv */
// Purpose: small word FIFO between pixel capture and output sequencer
// Assumes: DEPTH a power of two, at least 2
// Notes:   read data come from a register; flush empties it in one cycle
`timescale 1ns/100ps

module pixel_fifo #(
  parameter int WIDTH = 30,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic flush,
  // filling side
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  // draining side
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("pixel_fifo depth must be a power of two, at least 2");
  end

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] count;
    logic [WIDTH-1:0] data;
    logic valid;
  } fifo_state_type;

  fifo_state_type st;
  fifo_state_type next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic memRead;

  always_comb begin
    next_st = st;
    inReady = st.count != DEPTH_C;
    push = inValid && inReady;
    memRead = (st.count != '0) && (!st.valid || outReady);
    if (memRead) begin
      next_st.data = mem[st.rd];
      next_st.valid = 1'b1;
      next_st.rd = st.rd + 1'b1;
    end else if (outReady) begin
      next_st.valid = 1'b0;
    end
    if (push) begin
      next_st.wr = st.wr + 1'b1;
    end
    next_st.count = st.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, memRead};
    if (flush) begin
      next_st = '0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // storage has no reset; nothing reads a slot before it is written
  always_ff @(posedge mclk) begin
    if (ce && push && !flush) begin
      mem[st.wr] <= inData;
    end
  end

  assign outData = st.data;
  assign outValid = st.valid;
endmodule

/* bench/tmds_source_model.sv */
// Purpose: transmitter-side model that hands over one decoded word per pixel clock
// Assumes: the bench calls send once for each word, back to back within a frame
// Notes:   the clock stands low between calls; the word lines change once the high half ends
`timescale 1ns/100ps

module tmds_source_model
  import dvi_rx_pkg::*;
(
  // link
  output logic pixelClock,
  output link_word_type linkWord
);
  initial begin
    pixelClock = 1'b0;
    linkWord = '0;
  end

  // a 400 ns pixel period, eight mclk cycles, so the word never moves on a sampling edge
  task automatic send(input link_word_type w);
    linkWord = w;
    pixelClock = 1'b1;
    #200;
    pixelClock = 1'b0;
    // once the hold time is over, show a changed value rather than the stale word
    linkWord = ~w;
    #200;
  endtask
endmodule

/* bench/dvi_rx_pixel_output_bench.sv */
// Purpose: self-checking bench of the pixel output and link-activity block
// Assumes: LOST_PIX and FOUND_PIX are scaled down so that the run stays short
// Notes:   the monitor predicts every output slot from the words that were sent
`timescale 1ns/100ps
`include "dvi_rx_cfg.svh"

module dvi_rx_pixel_output_bench
  import dvi_rx_pkg::*;
;
  localparam int LOST = 200;
  localparam int FOUND = 16;

  logic mclk, rstn, ce, pixelClock;
  link_word_type linkWord;
  logic wide, offsetN, flip, fullN, outN;
  logic outClk, deOut, hsyncOut, vsyncOut, oeN, active, overflow;
  pixel_type evenBus, oddBus, expEven;
  logic [`USER_OUT_W-1:0] userOut;
  logic prevOutClk, inSlot, evenDue;
  int hiCnt;
  int err_count = 0;
  int check_count = 0;
  int cycles = 0;
  link_word_type exp[$];
  logic [2:0] modes [5] = '{3'h2, 3'h3, 3'h4, 3'h6, 3'h5};

  dvi_rx_pixel_output #(.LOST_PIX(LOST), .FOUND_PIX(FOUND), .FIFO_DEPTH(8)) dut (
    .mclk(mclk), .rstn(rstn), .ce(ce), .pixelClock(pixelClock), .linkWord(linkWord),
    .wideOutputSelect(wide), .offsetOutputsN(offsetN), .latchEdgeFlip(flip),
    .fullShutdownN(fullN), .outputShutdownN(outN), .outputPixelClock(outClk),
    .evenPixelBus(evenBus), .oddPixelBus(oddBus), .deOut(deOut), .hsyncOut(hsyncOut),
    .vsyncOut(vsyncOut), .userControlBits(userOut), .outputsOeN(oeN),
    .linkActiveFlag(active), .overflowFlag(overflow));
  tmds_source_model src (.pixelClock(pixelClock), .linkWord(linkWord));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // ----------------------------------------
  // checking helpers
  // ----------------------------------------
  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask

  task automatic close_out();
    $display("checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask

  task automatic send_words(input int n, input logic de);
    link_word_type w;
    repeat (n) begin
      w = link_word_type'($urandom);
      w.de = de;
      exp.push_back(w);
      src.send(w);
    end
  endtask

  // wide mode pairs the words: the first goes to the even bus, the second to the odd bus
  task automatic slot_check();
    link_word_type e, o, c;
    chk(exp.size() >= (wide ? 2 : 1), "slot without word");
    if (exp.size() < (wide ? 2 : 1)) return;
    e = exp.pop_front();
    o = wide ? exp.pop_front() : '0;
    c = wide ? o : e;
    chk(deOut === c.de && hsyncOut === c.hsync && vsyncOut === c.vsync, "controls");
    if (!c.de) chk(userOut === c.userBits[3:1], "user bits");
    chk(oddBus === o.pix || (wide && !o.de), "odd bus");
    if (e.de && wide && !offsetN) begin
      chk(evenBus !== e.pix, "even bus not staggered");
      expEven = e.pix;
      evenDue = 1'b1;
    end else if (e.de) chk(evenBus === e.pix, "even bus");
  endtask

  always @(negedge mclk) begin
    if (!rstn) begin
      prevOutClk = 1'b0;
      inSlot = 1'b0;
      evenDue = 1'b0;
      hiCnt = 0;
    end else begin
      if (evenDue) chk(evenBus === expEven, "staggered even bus");
      evenDue = 1'b0;
      if (outClk !== prevOutClk && inSlot) begin
        chk(hiCnt == (wide ? 4 : 2), "latch level width");
        inSlot = 1'b0;
      end
      if (outClk !== prevOutClk && outClk === flip) begin
        slot_check();
        inSlot = 1'b1;
        hiCnt = 0;
      end
      if (inSlot) hiCnt++;
      prevOutClk = outClk;
    end
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 16000) begin
      err_count++;
      $display("[ERR] %0t run did not finish", $time);
      close_out();
    end
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    {wide, offsetN, flip, fullN, outN} = 5'h0b;
    tick(12);
    chk(oeN === 1'b1 && active === 1'b0 && deOut === 1'b0, "reset values");
    rstn = 1'b1;
    tick(5);
    chk(oeN === 1'b0, "outputs driven");
    void'($urandom(10));
    send_words(128, 1'b0);
    chk(active === 1'b0, "flag without transitions");
    send_words(FOUND - 1, 1'b1);
    chk(active === 1'b0, "flag early");
    send_words(2, 1'b1);
    chk(active === 1'b1, "flag after acquire");
    $display("test link_up done");
    for (int i = 0; i < 5; i++) begin
      tick(40);
      chk(exp.size() == 0, "all words out");
      {wide, offsetN, flip} = modes[i];
      tick(10);
      send_words(128, 1'b0);
      send_words(16, 1'b1);
      chk(active === 1'b1, "flag held");
    end
    $display("test modes done");
    send_words(LOST - 20, 1'b0);
    send_words(1, 1'b1);
    send_words(LOST - 2, 1'b0);
    chk(active === 1'b1, "flag after restart");
    send_words(5, 1'b0);
    chk(active === 1'b0, "flag after quiet");
    send_words(FOUND + 2, 1'b1);
    chk(active === 1'b1, "flag after second acquire");
    $display("test quiet done");
    tick(40);
    outN = 1'b0;
    tick(3);
    chk(oeN === 1'b1 && active === 1'b1, "output shutdown");
    outN = 1'b1;
    tick(3);
    chk(oeN === 1'b0, "outputs back");
    fullN = 1'b0;
    tick(3);
    chk(oeN === 1'b1 && active === 1'b0, "full shutdown");
    fullN = 1'b1;
    tick(3);
    chk(oeN === 1'b0, "outputs back after full");
    $display("test shutdown done");
    // with the enable low every register holds, the pin synchronisers too
    ce = 1'b0;
    outN = 1'b0;
    tick(5);
    chk(oeN === 1'b0, "outputs frozen while disabled");
    ce = 1'b1;
    tick(3);
    chk(oeN === 1'b1, "output shutdown after enable");
    outN = 1'b1;
    tick(3);
    chk(oeN === 1'b0 && active === 1'b0, "outputs back after enable");
    // the word buffer in the data path must hand on every word, in order
    send_words(8, 1'b1);
    tick(40);
    chk(exp.size() == 0, "buffer passes every word");
    chk(overflow === 1'b0, "no pixel lost");
    $display("test enable done");
    close_out();
  end
endmodule
